// file: hw/cpu_core.sv
// Notes on behaviour
// - 8-bit accumulator holds operands and results
// - 8-bit index register forms indexed addresses
// - 16-bit program counter addresses next byte
// - Reset and reinit instruction load stack to 00FF
// - Stack pointer decrements on push, increments on pull
// - Stack addresses confined to 00C0 through 00FF
// - Stack wraps silently past 64 bytes
// - Call pushes two bytes, interrupt five
// - Five-bit condition codes, four flags plus mask
// - Half carry from bit 3 on adds
// - Masked interrupt stays pending until unmasked
// - Negative flag follows result sign
// - Zero flag follows zero result
// - Carry from arithmetic, bit tests, shifts
// - Unsigned product: high to index, low to accumulator
// - Two-byte branches, taken only on condition
// - Bit set and clear across page zero
// - Bit test-and-branch copies bit into carry
// - Read-modify-write writes back, test only reads
// - Register/memory ops use register and memory operand
`timescale 1ns/1ps
`default_nettype none
module cpu_core (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // Memory port
  output var  cpu_pkg::mem_req_t mem_req_o,
  input  wire logic [7:0]        mem_rdata_i,
  // Interrupt request
  input  wire logic              irq_i,
  // Register view
  output logic [7:0]             acc_o,
  output logic [7:0]             index_o,
  output logic [15:0]            program_counter_o,
  output logic [15:0]            stack_pointer_o,
  output var  cpu_pkg::ccr_t     condition_code_register_o
);

  cpu_pkg::state_t   state_reg, state_next;
  cpu_pkg::mem_req_t req_reg, req_next;
  cpu_pkg::ccr_t     ccr_reg, ccr_next;
  logic [7:0]  a_reg, a_next;
  logic [7:0]  x_reg, x_next;
  logic [15:0] pc_reg, pc_next;
  logic [15:0] ea_reg, ea_next;
  logic [5:0]  sp_reg, sp_next;
  logic [7:0]  op_reg, op_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        irq_pend_reg, irq_pend_next;
  logic        call_reg, call_next;
  logic        swi_reg, swi_next;

  logic [7:0]  d;
  logic [15:0] pc_inc;
  logic [15:0] rel_tgt;
  logic [15:0] sp_addr;
  logic [15:0] sp_up_addr;
  logic [15:0] prod;
  logic [3:0]  grp;
  logic [3:0]  lo;
  logic        br_cond;
  logic [7:0]  alu_r;
  logic [8:0]  sum;
  logic [8:0]  dif;
  logic [7:0]  alu_res;
  logic        alu_c;
  logic        alu_wa;
  logic        alu_wx;
  logic        alu_wc;
  logic        alu_wh;
  logic        alu_go;
  logic [3:0]  rmw_lo;
  logic [7:0]  rmw_v;
  logic [8:0]  rmw_out;
  logic [7:0]  frame_byte;

  function automatic cpu_pkg::mem_req_t rd_req(input logic [15:0] ad);
    rd_req = '{addr: ad, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
  endfunction

  function automatic cpu_pkg::mem_req_t wr_req(input logic [15:0] ad,
                                               input logic [7:0]  dat);
    wr_req = '{addr: ad, wdata: dat, rd: 1'b0, wr: 1'b1};
  endfunction

  // Returns {carry, result}
  function automatic logic [8:0] rmw_f(input logic [3:0] f,
                                       input logic [7:0] v,
                                       input logic       ci);
    case (f)
      cpu_pkg::R_NEG:  rmw_f = {v != 8'h00, 8'h00 - v};
      cpu_pkg::R_COM:  rmw_f = {1'b1, ~v};
      cpu_pkg::R_LSR:  rmw_f = {v[0], 1'b0, v[7:1]};
      cpu_pkg::R_ROR:  rmw_f = {v[0], ci, v[7:1]};
      cpu_pkg::R_ASR:  rmw_f = {v[0], v[7], v[7:1]};
      cpu_pkg::R_LSL:  rmw_f = {v[7], v[6:0], 1'b0};
      cpu_pkg::R_ROL:  rmw_f = {v[7], v[6:0], ci};
      cpu_pkg::R_DEC:  rmw_f = {ci, v - 8'h01};
      cpu_pkg::R_INC:  rmw_f = {ci, v + 8'h01};
      cpu_pkg::R_CLR:  rmw_f = {ci, 8'h00};
      default:         rmw_f = {ci, v};
    endcase
  endfunction

  // Shared operand and result paths
  always_comb begin
    d          = mem_rdata_i;
    pc_inc     = pc_reg + 16'h0001;
    rel_tgt    = pc_inc + {{8{d[7]}}, d};
    sp_addr    = {cpu_pkg::STACK_PAGE, sp_reg};
    sp_up_addr = {cpu_pkg::STACK_PAGE, sp_reg + 6'h01};
    prod       = {8'h00, a_reg} * {8'h00, x_reg};
    grp        = op_reg[7:4];
    lo         = op_reg[3:0];
    case (op_reg[3:1])
      3'h0:    br_cond = 1'b1;
      3'h1:    br_cond = ~(ccr_reg.c | ccr_reg.z);
      3'h2:    br_cond = ~ccr_reg.c;
      3'h3:    br_cond = ~ccr_reg.z;
      3'h4:    br_cond = ~ccr_reg.h;
      3'h5:    br_cond = ~ccr_reg.n;
      3'h6:    br_cond = ~ccr_reg.i;
      default: br_cond = irq_i;
    endcase
    br_cond = br_cond ^ op_reg[0];
    alu_r = (lo == cpu_pkg::A_CPX) ? x_reg : a_reg;
    sum = {1'b0, a_reg} + {1'b0, d}
        + {8'h00, (lo == cpu_pkg::A_ADC) & ccr_reg.c};
    dif = {1'b0, alu_r} - {1'b0, d}
        - {8'h00, (lo == cpu_pkg::A_SBC) & ccr_reg.c};
    alu_res = d;
    alu_c   = dif[8];
    alu_wa  = 1'b0;
    alu_wx  = 1'b0;
    alu_wc  = 1'b0;
    alu_wh  = 1'b0;
    case (lo)
      cpu_pkg::A_SUB, cpu_pkg::A_SBC: begin
        alu_res = dif[7:0];
        alu_wa  = 1'b1;
        alu_wc  = 1'b1;
      end
      cpu_pkg::A_CMP, cpu_pkg::A_CPX: begin
        alu_res = dif[7:0];
        alu_wc  = 1'b1;
      end
      cpu_pkg::A_AND: begin
        alu_res = a_reg & d;
        alu_wa  = 1'b1;
      end
      cpu_pkg::A_BITTEST: alu_res = a_reg & d;
      cpu_pkg::A_LOAD_A:  alu_wa = 1'b1;
      cpu_pkg::A_LOAD_X:  alu_wx = 1'b1;
      cpu_pkg::A_EOR: begin
        alu_res = a_reg ^ d;
        alu_wa  = 1'b1;
      end
      cpu_pkg::A_ORA: begin
        alu_res = a_reg | d;
        alu_wa  = 1'b1;
      end
      cpu_pkg::A_ADC, cpu_pkg::A_ADD: begin
        alu_res = sum[7:0];
        alu_c   = sum[8];
        alu_wa  = 1'b1;
        alu_wc  = 1'b1;
        alu_wh  = 1'b1;
      end
      default: alu_res = d;
    endcase
    rmw_lo  = (state_reg == cpu_pkg::S_FETCH) ? d[3:0] : lo;
    rmw_v   = (state_reg != cpu_pkg::S_FETCH) ? d : (d[4] ? x_reg : a_reg);
    rmw_out = rmw_f(rmw_lo, rmw_v, ccr_reg.c);
    case (cpu_pkg::SLOT_PCL - cnt_reg)
      cpu_pkg::SLOT_PCL: frame_byte = pc_reg[7:0];
      cpu_pkg::SLOT_PCH: frame_byte = pc_reg[15:8];
      cpu_pkg::SLOT_X:   frame_byte = x_reg;
      cpu_pkg::SLOT_A:   frame_byte = a_reg;
      default:           frame_byte = {cpu_pkg::CCR_PAD, ccr_reg};
    endcase
  end

  // Sequencer
  always_comb begin
    state_next    = state_reg;
    req_next      = '0;
    ccr_next      = ccr_reg;
    a_next        = a_reg;
    x_next        = x_reg;
    pc_next       = pc_reg;
    ea_next       = ea_reg;
    sp_next       = sp_reg;
    op_next       = op_reg;
    cnt_next      = cnt_reg;
    call_next     = call_reg;
    swi_next      = swi_reg;
    alu_go        = 1'b0;
    irq_pend_next = irq_pend_reg | irq_i;
    case (state_reg)
      cpu_pkg::S_FETCH: begin
        if (irq_pend_reg && !ccr_reg.i) begin
          irq_pend_next = irq_i;
          swi_next      = 1'b0;
          call_next     = 1'b0;
          req_next      = wr_req(sp_addr, pc_reg[7:0]);
          sp_next       = sp_reg - 6'h01;
          cnt_next      = 3'h1;
          state_next    = cpu_pkg::S_PUSH;
        end else begin
          op_next    = d;
          pc_next    = pc_inc;
          req_next   = rd_req(pc_inc);
          state_next = cpu_pkg::S_FETCH;
          case (d[7:4])
            cpu_pkg::G_RMW_A, cpu_pkg::G_RMW_X: begin
              if (d == cpu_pkg::OP_PRODUCT) begin
                x_next     = prod[15:8];
                a_next     = prod[7:0];
                ccr_next.h = 1'b0;
                ccr_next.c = 1'b0;
              end else begin
                if (d[4]) begin
                  x_next = rmw_out[7:0];
                end else begin
                  a_next = rmw_out[7:0];
                end
                ccr_next.c = rmw_out[8];
                ccr_next.n = rmw_out[7];
                ccr_next.z = rmw_out[7:0] == 8'h00;
              end
            end
            cpu_pkg::G_CTRL: begin
              if (d == cpu_pkg::OP_RTI || d == cpu_pkg::OP_RTS) begin
                call_next  = d == cpu_pkg::OP_RTS;
                cnt_next   = (d == cpu_pkg::OP_RTS) ? cpu_pkg::SLOT_PCH
                                                    : cpu_pkg::SLOT_CCR;
                sp_next    = sp_reg + 6'h01;
                req_next   = rd_req(sp_up_addr);
                state_next = cpu_pkg::S_PULL;
              end else if (d == cpu_pkg::OP_SWI) begin
                swi_next   = 1'b1;
                call_next  = 1'b0;
                req_next   = wr_req(sp_addr, pc_inc[7:0]);
                sp_next    = sp_reg - 6'h01;
                cnt_next   = 3'h1;
                state_next = cpu_pkg::S_PUSH;
              end
            end
            cpu_pkg::G_XFER: begin
              case (d)
                cpu_pkg::OP_TAX:       x_next = a_reg;
                cpu_pkg::OP_TXA:       a_next = x_reg;
                cpu_pkg::OP_CLC:       ccr_next.c = 1'b0;
                cpu_pkg::OP_SEC:       ccr_next.c = 1'b1;
                cpu_pkg::OP_CLI:       ccr_next.i = 1'b0;
                cpu_pkg::OP_SEI:       ccr_next.i = 1'b1;
                cpu_pkg::OP_SP_REINIT: sp_next = cpu_pkg::SP_RESET;
                default:               sp_next = sp_reg;
              endcase
            end
            cpu_pkg::G_IX, cpu_pkg::G_RMW_IX: begin
              ea_next    = {8'h00, x_reg};
              req_next   = '0;
              state_next = cpu_pkg::S_ADDR;
            end
            default: state_next = cpu_pkg::S_OPER;
          endcase
        end
      end
      cpu_pkg::S_OPER: begin
        pc_next    = pc_inc;
        req_next   = rd_req(pc_inc);
        state_next = cpu_pkg::S_FETCH;
        case (grp)
          cpu_pkg::G_BRANCH: begin
            pc_next  = br_cond ? rel_tgt : pc_inc;
            req_next = rd_req(br_cond ? rel_tgt : pc_inc);
          end
          cpu_pkg::G_IMM: begin
            if (lo == cpu_pkg::A_CALL) begin
              ea_next    = rel_tgt;
              req_next   = '0;
              state_next = cpu_pkg::S_ADDR;
            end else begin
              alu_go = 1'b1;
            end
          end
          cpu_pkg::G_EXT, cpu_pkg::G_IX2: begin
            ea_next    = {d, 8'h00};
            state_next = cpu_pkg::S_OPER2;
          end
          cpu_pkg::G_IX1, cpu_pkg::G_RMW_IX1: begin
            ea_next    = {8'h00, x_reg} + {8'h00, d};
            req_next   = '0;
            state_next = cpu_pkg::S_ADDR;
          end
          default: begin
            ea_next    = {8'h00, d};
            req_next   = '0;
            state_next = cpu_pkg::S_ADDR;
          end
        endcase
      end
      cpu_pkg::S_OPER2: begin
        ea_next    = {ea_reg[15:8], d}
                   + ((grp == cpu_pkg::G_IX2) ? {8'h00, x_reg} : 16'h0000);
        pc_next    = pc_inc;
        state_next = cpu_pkg::S_ADDR;
      end
      cpu_pkg::S_ADDR: begin
        req_next   = rd_req(ea_reg);
        state_next = cpu_pkg::S_MEM;
        if (grp >= cpu_pkg::G_IMM) begin
          case (lo)
            cpu_pkg::A_JUMP: begin
              pc_next    = ea_reg;
              state_next = cpu_pkg::S_FETCH;
            end
            cpu_pkg::A_CALL: begin
              call_next  = 1'b1;
              req_next   = wr_req(sp_addr, pc_reg[7:0]);
              sp_next    = sp_reg - 6'h01;
              cnt_next   = 3'h1;
              state_next = cpu_pkg::S_PUSH;
            end
            cpu_pkg::A_STORE_A, cpu_pkg::A_STORE_X: begin
              req_next   = wr_req(ea_reg, lo[3] ? x_reg : a_reg);
              ccr_next.n = lo[3] ? x_reg[7] : a_reg[7];
              ccr_next.z = (lo[3] ? x_reg : a_reg) == 8'h00;
              state_next = cpu_pkg::S_WB;
            end
            default: state_next = cpu_pkg::S_MEM;
          endcase
        end
      end
      cpu_pkg::S_MEM: begin
        req_next   = rd_req(pc_reg);
        state_next = cpu_pkg::S_FETCH;
        case (grp)
          cpu_pkg::G_BITBR: begin
            ccr_next.c = d[op_reg[3:1]];
            state_next = cpu_pkg::S_BREL;
          end
          cpu_pkg::G_BIT: begin
            req_next = wr_req(ea_reg, op_reg[0]
                         ? d & ~(8'h01 << op_reg[3:1])
                         : d | (8'h01 << op_reg[3:1]));
            state_next = cpu_pkg::S_WB;
          end
          cpu_pkg::G_RMW_DIR, cpu_pkg::G_RMW_IX1, cpu_pkg::G_RMW_IX: begin
            ccr_next.c = rmw_out[8];
            ccr_next.n = rmw_out[7];
            ccr_next.z = rmw_out[7:0] == 8'h00;
            if (lo != cpu_pkg::R_TEST) begin
              req_next   = wr_req(ea_reg, rmw_out[7:0]);
              state_next = cpu_pkg::S_WB;
            end
          end
          default: alu_go = 1'b1;
        endcase
      end
      cpu_pkg::S_BREL: begin
        pc_next    = (ccr_reg.c ^ op_reg[0]) ? rel_tgt : pc_inc;
        req_next   = rd_req((ccr_reg.c ^ op_reg[0]) ? rel_tgt : pc_inc);
        state_next = cpu_pkg::S_FETCH;
      end
      cpu_pkg::S_WB: begin
        req_next   = rd_req(pc_reg);
        state_next = cpu_pkg::S_FETCH;
      end
      cpu_pkg::S_PUSH: begin
        if (cnt_reg == (call_reg ? cpu_pkg::CALL_BYTES
                                 : cpu_pkg::INT_BYTES)) begin
          if (call_reg) begin
            pc_next    = ea_reg;
            req_next   = rd_req(ea_reg);
            state_next = cpu_pkg::S_FETCH;
          end else begin
            ccr_next.i = 1'b1;
            ea_next    = swi_reg ? cpu_pkg::VEC_SWI : cpu_pkg::VEC_IRQ;
            req_next   = rd_req(swi_reg ? cpu_pkg::VEC_SWI
                                        : cpu_pkg::VEC_IRQ);
            state_next = cpu_pkg::S_VEC_HI;
          end
        end else begin
          req_next = wr_req(sp_addr, frame_byte);
          sp_next  = sp_reg - 6'h01;
          cnt_next = cnt_reg + 3'h1;
        end
      end
      cpu_pkg::S_PULL: begin
        sp_next  = sp_reg + 6'h01;
        cnt_next = cnt_reg + 3'h1;
        req_next = rd_req(sp_up_addr);
        case (cnt_reg)
          cpu_pkg::SLOT_CCR: ccr_next = cpu_pkg::ccr_t'(d[4:0]);
          cpu_pkg::SLOT_A:   a_next = d;
          cpu_pkg::SLOT_X:   x_next = d;
          cpu_pkg::SLOT_PCH: pc_next = {d, pc_reg[7:0]};
          default: begin
            sp_next    = sp_reg;
            pc_next    = {pc_reg[15:8], d};
            req_next   = rd_req({pc_reg[15:8], d});
            state_next = cpu_pkg::S_FETCH;
          end
        endcase
      end
      cpu_pkg::S_VEC_HI: begin
        pc_next    = {d, 8'h00};
        req_next   = rd_req(ea_reg + 16'h0001);
        state_next = cpu_pkg::S_VEC_LO;
      end
      cpu_pkg::S_VEC_LO: begin
        pc_next    = {pc_reg[15:8], d};
        req_next   = rd_req({pc_reg[15:8], d});
        state_next = cpu_pkg::S_FETCH;
      end
      default: state_next = cpu_pkg::S_WB;
    endcase
    if (alu_go) begin
      if (alu_wa) a_next = alu_res;
      if (alu_wx) x_next = alu_res;
      if (alu_wc) ccr_next.c = alu_c;
      if (alu_wh) ccr_next.h = a_reg[4] ^ d[4] ^ sum[4];
      ccr_next.n = alu_res[7];
      ccr_next.z = alu_res == 8'h00;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg    <= cpu_pkg::S_VEC_HI;
      req_reg      <= '{addr: cpu_pkg::VEC_RESET, wdata: 8'h00,
                        rd: 1'b1, wr: 1'b0};
      ccr_reg      <= '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};
      a_reg        <= 8'h00;
      x_reg        <= 8'h00;
      pc_reg       <= 16'h0000;
      ea_reg       <= cpu_pkg::VEC_RESET;
      sp_reg       <= cpu_pkg::SP_RESET;
      op_reg       <= 8'h00;
      cnt_reg      <= 3'h0;
      irq_pend_reg <= 1'b0;
      call_reg     <= 1'b0;
      swi_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      req_reg      <= req_next;
      ccr_reg      <= ccr_next;
      a_reg        <= a_next;
      x_reg        <= x_next;
      pc_reg       <= pc_next;
      ea_reg       <= ea_next;
      sp_reg       <= sp_next;
      op_reg       <= op_next;
      cnt_reg      <= cnt_next;
      irq_pend_reg <= irq_pend_next;
      call_reg     <= call_next;
      swi_reg      <= swi_next;
    end
  end

  assign mem_req_o                 = req_reg;
  assign acc_o                     = a_reg;
  assign index_o                   = x_reg;
  assign program_counter_o         = pc_reg;
  assign stack_pointer_o           = {cpu_pkg::STACK_PAGE, sp_reg};
  assign condition_code_register_o = ccr_reg;

endmodule
`default_nettype wire

// file: hw/cpu_pkg.sv
package cpu_pkg;

  // Stack page: upper ten address bits are fixed
  localparam logic [9:0]  STACK_PAGE   = 10'h003;
  localparam logic [5:0]  SP_RESET     = 6'h3F;
  localparam logic [2:0]  CCR_PAD      = 3'h7;

  // Vector addresses
  localparam logic [15:0] VEC_RESET    = 16'h1FFE;
  localparam logic [15:0] VEC_SWI      = 16'h1FFC;
  localparam logic [15:0] VEC_IRQ      = 16'h1FFA;

  // Bytes per stack frame
  localparam logic [2:0]  CALL_BYTES   = 3'h2;
  localparam logic [2:0]  INT_BYTES    = 3'h5;

  // Stack frame slot, in pull order
  localparam logic [2:0]  SLOT_CCR     = 3'h0;
  localparam logic [2:0]  SLOT_A       = 3'h1;
  localparam logic [2:0]  SLOT_X       = 3'h2;
  localparam logic [2:0]  SLOT_PCH     = 3'h3;
  localparam logic [2:0]  SLOT_PCL     = 3'h4;

  // Opcode groups (upper nibble)
  localparam logic [3:0]  G_BITBR      = 4'h0;
  localparam logic [3:0]  G_BIT        = 4'h1;
  localparam logic [3:0]  G_BRANCH     = 4'h2;
  localparam logic [3:0]  G_RMW_DIR    = 4'h3;
  localparam logic [3:0]  G_RMW_A      = 4'h4;
  localparam logic [3:0]  G_RMW_X      = 4'h5;
  localparam logic [3:0]  G_RMW_IX1    = 4'h6;
  localparam logic [3:0]  G_RMW_IX     = 4'h7;
  localparam logic [3:0]  G_CTRL       = 4'h8;
  localparam logic [3:0]  G_XFER       = 4'h9;
  localparam logic [3:0]  G_IMM        = 4'hA;
  localparam logic [3:0]  G_EXT        = 4'hC;
  localparam logic [3:0]  G_IX2        = 4'hD;
  localparam logic [3:0]  G_IX1        = 4'hE;
  localparam logic [3:0]  G_IX         = 4'hF;

  // Control opcodes
  localparam logic [7:0]  OP_RTI       = 8'h80;
  localparam logic [7:0]  OP_RTS       = 8'h81;
  localparam logic [7:0]  OP_SWI       = 8'h83;
  localparam logic [7:0]  OP_PRODUCT   = 8'h42;
  localparam logic [7:0]  OP_TAX       = 8'h97;
  localparam logic [7:0]  OP_CLC       = 8'h98;
  localparam logic [7:0]  OP_SEC       = 8'h99;
  localparam logic [7:0]  OP_CLI       = 8'h9A;
  localparam logic [7:0]  OP_SEI       = 8'h9B;
  localparam logic [7:0]  OP_SP_REINIT = 8'h9C;
  localparam logic [7:0]  OP_TXA       = 8'h9F;

  // Register/memory operations (lower nibble)
  localparam logic [3:0]  A_SUB        = 4'h0;
  localparam logic [3:0]  A_CMP        = 4'h1;
  localparam logic [3:0]  A_SBC        = 4'h2;
  localparam logic [3:0]  A_CPX        = 4'h3;
  localparam logic [3:0]  A_AND        = 4'h4;
  localparam logic [3:0]  A_BITTEST    = 4'h5;
  localparam logic [3:0]  A_LOAD_A     = 4'h6;
  localparam logic [3:0]  A_STORE_A    = 4'h7;
  localparam logic [3:0]  A_EOR        = 4'h8;
  localparam logic [3:0]  A_ADC        = 4'h9;
  localparam logic [3:0]  A_ORA        = 4'hA;
  localparam logic [3:0]  A_ADD        = 4'hB;
  localparam logic [3:0]  A_JUMP       = 4'hC;
  localparam logic [3:0]  A_CALL       = 4'hD;
  localparam logic [3:0]  A_LOAD_X     = 4'hE;
  localparam logic [3:0]  A_STORE_X    = 4'hF;

  // Read-modify-write operations (lower nibble)
  localparam logic [3:0]  R_NEG        = 4'h0;
  localparam logic [3:0]  R_COM        = 4'h3;
  localparam logic [3:0]  R_LSR        = 4'h4;
  localparam logic [3:0]  R_ROR        = 4'h6;
  localparam logic [3:0]  R_ASR        = 4'h7;
  localparam logic [3:0]  R_LSL        = 4'h8;
  localparam logic [3:0]  R_ROL        = 4'h9;
  localparam logic [3:0]  R_DEC        = 4'hA;
  localparam logic [3:0]  R_INC        = 4'hC;
  localparam logic [3:0]  R_TEST       = 4'hD;
  localparam logic [3:0]  R_CLR        = 4'hF;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } ccr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } mem_req_t;

  typedef enum logic [3:0] {
    S_FETCH  = 4'h0,
    S_OPER   = 4'h1,
    S_OPER2  = 4'h2,
    S_ADDR   = 4'h3,
    S_MEM    = 4'h4,
    S_BREL   = 4'h5,
    S_WB     = 4'h6,
    S_PUSH   = 4'h7,
    S_PULL   = 4'h8,
    S_VEC_HI = 4'h9,
    S_VEC_LO = 4'hA
  } state_t;

endpackage

// file: sim/cpu_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_checker (
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input wire cpu_pkg::mem_req_t mem_req_o,
  input wire logic [15:0]       stack_pointer_o,
  input wire cpu_pkg::ccr_t     condition_code_register_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic stk;
  assign stk = mem_req_o.addr[15:6] == 10'h003;
  property p_sp_page; stack_pointer_o[15:6] == 10'h003; endproperty
  a_sp_page: assert property (p_sp_page)
    else $error("stack pointer left its page");
  property p_reset_state;
    $rose(rst_n_i) |->
      stack_pointer_o == 16'h00FF && condition_code_register_o.i;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong stack pointer or mask after reset");
  property p_reset_fetch;
    $rose(rst_n_i) |-> mem_req_o.rd && mem_req_o.addr == 16'h1FFE
      ##1 mem_req_o.rd && mem_req_o.addr == 16'h1FFF;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch)
    else $error("reset vector not fetched");
  property p_push_addr;
    mem_req_o.wr && stk |->
      mem_req_o.addr[5:0] == stack_pointer_o[5:0] + 6'h01;
  endproperty
  a_push_addr: assert property (p_push_addr)
    else $error("push not at stack pointer");
  property p_push_dec;
    (mem_req_o.wr && stk) ##1 (mem_req_o.wr && stk) |->
      stack_pointer_o[5:0] == $past(stack_pointer_o[5:0]) - 6'h01;
  endproperty
  a_push_dec: assert property (p_push_dec)
    else $error("stack pointer not decremented");
  property p_pull_inc;
    mem_req_o.rd && stk |->
      stack_pointer_o[5:0] == mem_req_o.addr[5:0];
  endproperty
  a_pull_inc: assert property (p_pull_inc)
    else $error("stack pointer not incremented");
  property p_int_five;
    mem_req_o.rd && mem_req_o.addr == 16'h1FFA |->
      $past(mem_req_o.wr, 1) && $past(mem_req_o.wr, 5);
  endproperty
  a_int_five: assert property (p_int_five)
    else $error("interrupt frame not five bytes");
  property p_int_mask;
    mem_req_o.rd && mem_req_o.addr == 16'h1FFA |->
      !$past(condition_code_register_o.i, 6);
  endproperty
  a_int_mask: assert property (p_int_mask)
    else $error("interrupt taken while masked");
endmodule
bind cpu_core cpu_core_checker u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .mem_req_o(mem_req_o),
  .stack_pointer_o(stack_pointer_o),
  .condition_code_register_o(condition_code_register_o));
`default_nettype wire

// file: sim/cpu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_mem_model (
  input  wire logic              clock_i,
  input  wire cpu_pkg::mem_req_t mem_req_i,
  output logic [7:0]             mem_rdata_o
);
  logic [7:0] mem [0:65535];
  // Outside a read the bus shows inverted data, so stale bytes never pass
  assign mem_rdata_o = mem_req_i.rd ? mem[mem_req_i.addr]
                                    : ~mem[mem_req_i.addr];
  always @(posedge clock_i) begin
    if (mem_req_i.wr) begin
      mem[mem_req_i.addr] <= mem_req_i.wdata;
    end
  end
endmodule
`default_nettype wire

// file: sim/cpu_programming_model_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_programming_model_tb;
  logic              clock_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              irq_i   = 1'b0;
  cpu_pkg::mem_req_t mem_req;
  cpu_pkg::ccr_t     condition_code_register;
  logic [7:0]        rdata, acc, idx;
  logic [15:0]       pc, sp;
  int                n_mismatch = 0;
  int                checks_done = 0;
  always #20 clock_i = ~clock_i;
  cpu_core dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .mem_req_o(mem_req),
    .mem_rdata_i(rdata), .irq_i(irq_i), .acc_o(acc), .index_o(idx),
    .program_counter_o(pc), .stack_pointer_o(sp),
    .condition_code_register_o(condition_code_register));
  cpu_mem_model mem (.clock_i(clock_i), .mem_req_i(mem_req),
    .mem_rdata_o(rdata));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // Flag byte stacked on interrupt entry after the add, mask clear
  function automatic logic [7:0] flags(input logic [7:0] p, q);
    logic [8:0] s;
    s = {1'b0, p} + {1'b0, q};
    return {3'b111, ({1'b0, p[3:0]} + {1'b0, q[3:0]}) > 5'h0F, 1'b0,
            s[7], s[7:0] == 8'h00, s[8]};
  endfunction
  initial begin
    logic [7:0]  a, x, p, q, r;
    logic [7:0]  prog [22];
    logic [2:0]  b;
    logic [15:0] prod;
    int          k;
    void'($urandom(98));
    for (int it = 0; it < 20; it++) begin
      a = 8'($urandom());
      x = 8'($urandom());
      p = 8'($urandom());
      q = 8'($urandom());
      r = 8'($urandom());
      b = 3'($urandom());
      if (it == 0) begin
        a = 8'hFF; x = 8'hFF; p = 8'h88; q = 8'h88;
      end
      if (it == 1) begin
        x = 8'h00; p = 8'h08; q = 8'h08;
      end
      prod = 16'(a) * 16'(x);
      prog = '{8'hA6, a, 8'hAE, x, 8'h42, 8'hB7, 8'h10, 8'hBF, 8'h11,
               8'h11 + {4'h0, b, 1'b0}, 8'h20, 8'hA6, p, 8'hAB, q,
               8'hAD, 8'h04, 8'h9C, 8'h9A, 8'h20, 8'hFE, 8'h81};
      @(negedge clock_i);
      rst_n_i = 1'b0;
      for (k = 0; k < 22; k++) mem.mem[16'h0100 + k] = prog[k];
      mem.mem[16'h1FFE] = 8'h01; mem.mem[16'h1FFF] = 8'h00;
      mem.mem[16'h1FFA] = 8'h02; mem.mem[16'h1FFB] = 8'h00;
      mem.mem[16'h0200] = 8'h20; mem.mem[16'h0201] = 8'hFE;
      mem.mem[16'h0020] = r;
      repeat (2) @(negedge clock_i);
      rst_n_i = 1'b1;
      // Interrupt arrives while masked and must wait for the unmask
      repeat (1 + $urandom() % 6) @(negedge clock_i);
      irq_i = 1'b1;
      @(negedge clock_i);
      irq_i = 1'b0;
      for (k = 0; k < 300 && !(mem_req.rd === 1'b1 &&
           mem_req.addr === 16'h0200); k++) @(negedge clock_i);
      if (k == 300) begin
        n_mismatch++;
        break;
      end
      chk("product low", {8'h00, prod[7:0]}, {8'h00, mem.mem[16'h0010]});
      chk("product high", {8'h00, prod[15:8]}, {8'h00, mem.mem[16'h0011]});
      chk("index", {8'h00, prod[15:8]}, {8'h00, idx});
      chk("bit clear", {8'h00, r & ~(8'h01 << b)}, {8'h00, mem.mem[16'h0020]});
      chk("sum", {8'h00, 8'(p + q)}, {8'h00, acc});
      chk("stacked acc", {8'h00, 8'(p + q)}, {8'h00, mem.mem[16'h00FC]});
      chk("stacked index", {8'h00, prod[15:8]}, {8'h00, mem.mem[16'h00FD]});
      chk("stacked pc", 16'h0113, {mem.mem[16'h00FE], mem.mem[16'h00FF]});
      chk("stacked flags", {8'h00, flags(p, q)}, {8'h00, mem.mem[16'h00FB]});
      chk("stack pointer", 16'h00FA, sp);
      chk("mask", 16'h0001, {15'h0000, condition_code_register.i});
      chk("program counter", 16'h0200, pc);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
